// ### pfi_fault_modes.sv
// Phase sequencer of the control PWM timer with fault input mode handling.
`timescale 1ns/1ps

// Behaviour
// - Mode 1: fault in own phases jumps to opposite dead time and holds while active.
// - Mode 1: after release the counter resumes in that opposite dead time.
// - Modes 1-3: input A triggers its jump only in A phases; B likewise.
// - Mode 2: jump, run opposite dead and on-time, then hold while fault active.
// - Mode 2: fault gone before opposite phases end means no waiting.
// - Mode 3: opposite dead and on-time repeat while the fault stays active.
// - Mode 3: on release the running phase completes, then normal order resumes.
// - Mode 4: either input forces both outputs off; counter unaffected.
// - Mode 5: fault during on-time kills outputs, jumps to opposite dead time.
// - Mode 5: while active, on-time starts become dead times; release completes dead time.
// - Mode 6: jump to next dead time, hold while active, resume with dead time.
// - Mode 7: fault stops outputs and counter until software restart.
// - Mode 7: fault still high at restart stops everything again at once.
// - Mode 7: restart always begins at dead time A.
// - Mode 8: rising edge in own on-time kills output, jumps to opposite dead time.
// - Mode 9: rising edge in own on-time blocks output for rest of on-time.
// - Mode 10: output held off while the fault level is active; counter unaffected.
// - Mode 10: release within own on-time keeps output off until that on-time ends.
module pfi_fault_modes (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic arst_n,
  // Counter clock enable and software restart command
  input wire logic cnt_en,
  input wire logic restart,
  // Fault events, asynchronous to ref_clk
  input wire logic fault_a,
  input wire logic fault_b,
  // Configuration
  input wire pfi_pkg::pfi_cfg_t fault_input_select,
  input wire pfi_pkg::pfi_dur_t dur,
  // Waveforms and status
  output logic waveform_out_a,
  output logic waveform_out_b,
  output pfi_pkg::pfi_phase_t phase,
  output logic [pfi_pkg::CNT_W-1:0] count,
  output logic stopped
);
  import pfi_pkg::*;

  typedef struct packed {
    logic [1:0] meta;
    logic [1:0] syn;
    logic [1:0] prv;
    logic [1:0] pend;
    logic [1:0] blk;
    logic stop;
    pfi_phase_t ph;
    logic [CNT_W-1:0] cnt;
    logic wo_a;
    logic wo_b;
  } pfi_state_t;

  localparam pfi_state_t ST_RESET = '{
    meta: 2'h0, syn: 2'h0, prv: 2'h0, pend: 2'h0, blk: 2'h0, stop: 1'b0,
    ph: PH_DTA, cnt: CNT_ZERO, wo_a: 1'b0, wo_b: 1'b0
  };

  logic [1:0] rst_sync_reg;
  logic rst_n;
  pfi_state_t state_reg;
  pfi_state_t state_next;

  logic [1:0] flt;
  logic [1:0] rise;
  logic [SEL_W-1:0] sel [2];
  logic end_ph;
  logic hold;
  logic jump;
  logic kill;
  pfi_phase_t jtgt;
  pfi_phase_t atgt;

  // Own phases of input i: 0 is A, 1 is B.
  function automatic logic own_ph(input int i, input pfi_phase_t ph);
    own_ph = (i == 0) ? (ph == PH_DTA || ph == PH_OTA) : (ph == PH_DTB || ph == PH_OTB);
  endfunction : own_ph

  function automatic pfi_phase_t own_on(input int i);
    own_on = (i == 0) ? PH_OTA : PH_OTB;
  endfunction : own_on

  function automatic pfi_phase_t opp_dead(input int i);
    opp_dead = (i == 0) ? PH_DTB : PH_DTA;
  endfunction : opp_dead

  function automatic pfi_phase_t opp_on(input int i);
    opp_on = (i == 0) ? PH_OTB : PH_OTA;
  endfunction : opp_on

  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      rst_sync_reg <= 2'h0;
    end else begin
      rst_sync_reg <= {rst_sync_reg[0], 1'b1};
    end
  end

  assign rst_n = rst_sync_reg[1];
  assign flt = state_reg.syn;
  assign rise = state_reg.syn & ~state_reg.prv;
  assign sel[0] = fault_input_select.sel_a;
  assign sel[1] = fault_input_select.sel_b;
  assign end_ph = cnt_en && (state_reg.cnt >= pfi_limit(state_reg.ph, dur));

  always_comb begin
    state_next = state_reg;
    state_next.meta = {fault_b, fault_a};
    state_next.syn = state_reg.meta;
    state_next.prv = state_reg.syn;
    hold = 1'b0;
    jump = 1'b0;
    kill = 1'b0;
    jtgt = state_reg.ph;
    atgt = pfi_next_ph(state_reg.ph);
    // Restart first, so a mode 7 fault seen in the same cycle stops again.
    if (restart && state_reg.stop) begin
      state_next.stop = 1'b0;
      state_next.ph = PH_DTA;
      state_next.cnt = CNT_ZERO;
    end
    for (int i = 0; i < 2; i++) begin
      if (sel[i] != SEL_JUMP_WAIT && sel[i] != SEL_EXEC_WAIT) begin
        state_next.pend[i] = 1'b0;
      end
      if (state_reg.ph != own_on(i) && !(sel[i] == SEL_LEVEL_KEEP && flt[i])) begin
        state_next.blk[i] = 1'b0;
      end
      unique case (sel[i])
        SEL_JUMP_WAIT: begin
          if (flt[i] && own_ph(i, state_reg.ph)) begin
            jump = 1'b1;
            jtgt = opp_dead(i);
            state_next.pend[i] = 1'b1;
          end
          if (state_reg.pend[i]) begin
            hold = hold | flt[i];
            state_next.pend[i] = flt[i];
          end
        end
        SEL_EXEC_WAIT: begin
          if (flt[i] && own_ph(i, state_reg.ph)) begin
            jump = 1'b1;
            jtgt = opp_dead(i);
            state_next.pend[i] = 1'b1;
          end
          if (state_reg.pend[i] && state_reg.ph == opp_on(i) && end_ph) begin
            hold = hold | flt[i];
            state_next.pend[i] = flt[i];
          end
        end
        SEL_EXEC_ACT: begin
          if (flt[i] && own_ph(i, state_reg.ph)) begin
            jump = 1'b1;
            jtgt = opp_dead(i);
          end
          if (flt[i] && state_reg.ph == opp_on(i)) begin
            atgt = opp_dead(i);
          end
          // Once released, the running phase simply ends into normal order.
        end
        SEL_ALL_KEEP: begin
          kill = kill | flt[i];
        end
        SEL_ALL_DEAD, SEL_ALL_WAIT: begin
          kill = kill | flt[i];
          if (flt[i] && (state_reg.ph == PH_OTA || state_reg.ph == PH_OTB)) begin
            jump = 1'b1;
            jtgt = pfi_next_ph(state_reg.ph);
          end
          if (flt[i] && (state_reg.ph == PH_DTA || state_reg.ph == PH_DTB)) begin
            atgt = pfi_next_ph(pfi_next_ph(state_reg.ph));
            if (sel[i] == SEL_ALL_WAIT && state_reg.cnt == CNT_ZERO) begin
              hold = 1'b1;
            end
          end
        end
        SEL_ALL_SW: begin
          if (flt[i]) begin
            state_next.stop = 1'b1;
          end
        end
        SEL_EDGE_JUMP: begin
          if (rise[i] && state_reg.ph == own_on(i)) begin
            jump = 1'b1;
            jtgt = opp_dead(i);
          end
        end
        SEL_EDGE_KEEP: begin
          if (rise[i] && state_reg.ph == own_on(i)) begin
            state_next.blk[i] = 1'b1;
          end
        end
        SEL_LEVEL_KEEP: begin
          if (flt[i]) begin
            state_next.blk[i] = 1'b1;
          end
        end
        default: begin
          // No action and reserved codes leave flow and outputs alone.
        end
      endcase
    end
    if (!state_reg.stop && !(restart && state_reg.stop)) begin
      if (jump) begin
        state_next.ph = jtgt;
        state_next.cnt = CNT_ZERO;
      end else if (hold) begin
        state_next.cnt = state_reg.cnt;
      end else if (end_ph) begin
        state_next.ph = atgt;
        state_next.cnt = CNT_ZERO;
      end else if (cnt_en) begin
        state_next.cnt = state_reg.cnt + CNT_ONE;
      end
    end
    // Outputs are registered from the next phase so a jump drops them in the same edge.
    kill = kill | state_next.stop;
    state_next.wo_a = (state_next.ph == PH_OTA) && !kill && !state_next.blk[0];
    state_next.wo_b = (state_next.ph == PH_OTB) && !kill && !state_next.blk[1];
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      state_reg <= ST_RESET;
    end else begin
      state_reg <= state_next;
    end
  end

  assign waveform_out_a = state_reg.wo_a;
  assign waveform_out_b = state_reg.wo_b;
  assign phase = state_reg.ph;
  assign count = state_reg.cnt;
  assign stopped = state_reg.stop;

  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rst_n);

  // Jump and hold properties expect the other input in no-action mode, so the two inputs never race for a jump.
  sequence fault_a_own_s;
    flt[0] && (state_reg.ph == PH_DTA || state_reg.ph == PH_OTA) && !state_reg.stop && sel[1] == SEL_NONE;
  endsequence

  sequence otb_end_s;
    phase == PH_OTB && end_ph && !stopped && sel[1] == SEL_NONE;
  endsequence

  mode1_jump_a: assert property (((sel[0] == SEL_JUMP_WAIT && !restart) and fault_a_own_s)
    |=> phase == PH_DTB)
    else $error("mode 1 fault did not jump to dead time B");
  mode1_wait_a: assert property (sel[0] == SEL_JUMP_WAIT && state_reg.pend[0] && flt[0] && !state_reg.stop
    && sel[1] == SEL_NONE |=> $stable(count) && phase == PH_DTB)
    else $error("mode 1 counter did not wait in dead time B");
  mode2_hold_a: assert property (((sel[0] == SEL_EXEC_WAIT && state_reg.pend[0] && flt[0]) and otb_end_s)
    |=> phase == PH_OTB && $stable(count))
    else $error("mode 2 counter did not wait after the opposite on-time");
  mode2_go_a: assert property (((sel[0] == SEL_EXEC_WAIT && state_reg.pend[0] && !flt[0]) and otb_end_s)
    |=> phase == PH_DTA && count == CNT_ZERO)
    else $error("mode 2 counter waited although the fault was gone");
  mode3_repeat_a: assert property (((sel[0] == SEL_EXEC_ACT && flt[0]) and otb_end_s)
    |=> phase == PH_DTB && count == CNT_ZERO)
    else $error("mode 3 did not repeat the opposite dead time");
  mode3_release_a: assert property (((sel[0] == SEL_EXEC_ACT && !flt[0]) and otb_end_s)
    |=> phase == PH_DTA && count == CNT_ZERO)
    else $error("mode 3 did not return to the normal order");
  mode4_kill_a: assert property ((sel[0] == SEL_ALL_KEEP && flt[0]) || (sel[1] == SEL_ALL_KEEP && flt[1])
    |=> !waveform_out_a && !waveform_out_b)
    else $error("mode 4 fault left an output active");
  mode5_jump_a: assert property (sel[0] == SEL_ALL_DEAD && flt[0] && phase == PH_OTA && !stopped
    && sel[1] == SEL_NONE |=> phase == PH_DTB && count == CNT_ZERO && !waveform_out_a)
    else $error("mode 5 fault did not jump to dead time B");
  mode6_hold_a: assert property (sel[0] == SEL_ALL_WAIT && sel[1] == SEL_NONE && flt[0] && !stopped
    && count == CNT_ZERO && (phase == PH_DTA || phase == PH_DTB) |=> $stable(phase) && count == CNT_ZERO)
    else $error("mode 6 counter did not wait in the dead time");
  mode7_stop_a: assert property ((sel[0] == SEL_ALL_SW && flt[0]) || (sel[1] == SEL_ALL_SW && flt[1])
    |=> stopped && !waveform_out_a && !waveform_out_b)
    else $error("mode 7 fault did not stop the timer");
  mode7_stay_a: assert property (stopped && !restart |=> stopped && $stable(count) && $stable(phase))
    else $error("stopped timer moved without restart");
  mode7_again_a: assert property (stopped && restart
    && ((sel[0] == SEL_ALL_SW && flt[0]) || (sel[1] == SEL_ALL_SW && flt[1])) |=> stopped)
    else $error("restart with fault high did not stop again");
  mode7_restart_a: assert property (stopped && restart |=> phase == PH_DTA && count == CNT_ZERO)
    else $error("restart did not begin at dead time A");
  mode8_edge_a: assert property (sel[1] == SEL_EDGE_JUMP && rise[1] && phase == PH_OTB && !stopped
    && sel[0] == SEL_NONE |=> phase == PH_DTA && !waveform_out_b)
    else $error("mode 8 edge did not jump to dead time A");
  mode9_block_a: assert property (sel[0] == SEL_EDGE_KEEP && rise[0] && phase == PH_OTA
    ##1 phase == PH_OTA |-> !waveform_out_a)
    else $error("mode 9 edge did not block output A");
  mode10_level_a: assert property (sel[0] == SEL_LEVEL_KEEP && flt[0] |=> !waveform_out_a)
    else $error("mode 10 fault left output A active");

endmodule : pfi_fault_modes

// ### pfi_pkg.sv
// Package for the fault input mode block: types, mode codes and phase helpers.
package pfi_pkg;

  localparam int CNT_W = 12;
  localparam int SEL_W = 4;

  // Fault input mode codes.
  localparam logic [SEL_W-1:0] SEL_NONE = 4'h0;
  localparam logic [SEL_W-1:0] SEL_JUMP_WAIT = 4'h1;
  localparam logic [SEL_W-1:0] SEL_EXEC_WAIT = 4'h2;
  localparam logic [SEL_W-1:0] SEL_EXEC_ACT = 4'h3;
  localparam logic [SEL_W-1:0] SEL_ALL_KEEP = 4'h4;
  localparam logic [SEL_W-1:0] SEL_ALL_DEAD = 4'h5;
  localparam logic [SEL_W-1:0] SEL_ALL_WAIT = 4'h6;
  localparam logic [SEL_W-1:0] SEL_ALL_SW = 4'h7;
  localparam logic [SEL_W-1:0] SEL_EDGE_JUMP = 4'h8;
  localparam logic [SEL_W-1:0] SEL_EDGE_KEEP = 4'h9;
  localparam logic [SEL_W-1:0] SEL_LEVEL_KEEP = 4'hA;

  localparam logic [CNT_W-1:0] CNT_ZERO = 12'h000;
  localparam logic [CNT_W-1:0] CNT_ONE = 12'h001;

  typedef enum logic [3:0] {
    PH_DTA = 4'h1,
    PH_OTA = 4'h2,
    PH_DTB = 4'h4,
    PH_OTB = 4'h8
  } pfi_phase_t;

  // Per-input mode fields, as written by software.
  typedef struct packed {
    logic [SEL_W-1:0] sel_b;
    logic [SEL_W-1:0] sel_a;
  } pfi_cfg_t;

  // Last count value of each phase; a phase lasts its value plus one cycles.
  typedef struct packed {
    logic [CNT_W-1:0] ot_b;
    logic [CNT_W-1:0] dt_b;
    logic [CNT_W-1:0] ot_a;
    logic [CNT_W-1:0] dt_a;
  } pfi_dur_t;

  function automatic pfi_phase_t pfi_next_ph(input pfi_phase_t ph);
    unique case (ph)
      PH_DTA: pfi_next_ph = PH_OTA;
      PH_OTA: pfi_next_ph = PH_DTB;
      PH_DTB: pfi_next_ph = PH_OTB;
      default: pfi_next_ph = PH_DTA;
    endcase
  endfunction : pfi_next_ph

  function automatic logic [CNT_W-1:0] pfi_limit(input pfi_phase_t ph, input pfi_dur_t d);
    unique case (ph)
      PH_DTA: pfi_limit = d.dt_a;
      PH_OTA: pfi_limit = d.ot_a;
      PH_DTB: pfi_limit = d.dt_b;
      default: pfi_limit = d.ot_b;
    endcase
  endfunction : pfi_limit

endpackage : pfi_pkg

// ### pfi_evt_src.sv
// Fault event source model standing in for the on-chip event routing.
`timescale 1ns/1ps
module pfi_evt_src (
  // Clock
  input wire logic ref_clk,
  // Fault event levels
  output logic fault_a,
  output logic fault_b
);
  initial begin
    fault_a = 1'b0;
    fault_b = 1'b0;
  end

  // Levels change only after a falling edge, so they never race the block's sampling edge.
  task automatic drive(input logic a, input logic b);
    @(negedge ref_clk);
    fault_a = a;
    fault_b = b;
  endtask : drive
endmodule : pfi_evt_src

// ### pfi_fault_modes_test.sv
// Self-checking testbench for the fault input mode sequencer.
`timescale 1ns/1ps
module pfi_fault_modes_test;
  import pfi_pkg::*;
  logic ref_clk;
  logic arst_n;
  logic cnt_en;
  logic restart;
  logic fault_a;
  logic fault_b;
  pfi_cfg_t sel;
  pfi_dur_t dur;
  logic waveform_out_a;
  logic waveform_out_b;
  pfi_phase_t phase;
  logic [CNT_W-1:0] count;
  logic stopped;
  int failures = 0;
  int checked = 0;
  int cycles = 0;

  pfi_evt_src u_src (
    .ref_clk(ref_clk),
    .fault_a(fault_a),
    .fault_b(fault_b)
  );

  pfi_fault_modes u_dut (
    .ref_clk(ref_clk),
    .arst_n(arst_n),
    .cnt_en(cnt_en),
    .restart(restart),
    .fault_a(fault_a),
    .fault_b(fault_b),
    .fault_input_select(sel),
    .dur(dur),
    .waveform_out_a(waveform_out_a),
    .waveform_out_b(waveform_out_b),
    .phase(phase),
    .count(count),
    .stopped(stopped)
  );

  initial begin
    ref_clk = 1'b0;
    forever #2 ref_clk = ~ref_clk;
  end

  // A hung wait must still end in a verdict.
  always @(posedge ref_clk) begin
    cycles++;
    if (cycles == 5000) begin
      failures++;
      stop_test();
    end
  end

  task automatic stop_test();
    if (failures == 0 && checked > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask : stop_test

  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    checked++;
    if (seen !== exp) begin
      failures++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  task automatic ticks(input int n);
    repeat (n) @(negedge ref_clk);
  endtask : ticks

  // Waits for the first cycle of a phase; a bounded wait that runs out after 100 cycles is a mismatch.
  task automatic wait_ph(input pfi_phase_t ph);
    int i;
    i = 0;
    while (!(phase === ph && count === CNT_ZERO) && i < 100) begin
      @(negedge ref_clk);
      i++;
    end
    check({phase, count}, {ph, CNT_ZERO});
  endtask : wait_ph

  task automatic set_mode(input logic [3:0] a, input logic [3:0] b);
    // Every mode is legal in this four-phase flow; the old fault level drains out of the synchroniser first.
    ticks(4);
    sel = {b, a};
  endtask : set_mode

  task automatic t_none();
    set_mode(4'hF, 4'hB);
    wait_ph(PH_OTA);
    u_src.drive(1'b1, 1'b1);
    ticks(4);
    check(16'(waveform_out_a), 16'h0001);
    check(16'(phase), 16'(PH_OTA));
    u_src.drive(1'b0, 1'b0);
  endtask : t_none

  task automatic t_mode1();
    set_mode(SEL_JUMP_WAIT, SEL_NONE);
    wait_ph(PH_DTB);
    u_src.drive(1'b1, 1'b0);
    wait_ph(PH_OTB);
    ticks(2);
    check(16'(waveform_out_b), 16'h0001);
    ticks(10);
    check(16'(phase), 16'(PH_DTB));
    check(16'(waveform_out_a), 16'h0000);
    ticks(6);
    check(16'(count), 16'h0000);
    u_src.drive(1'b0, 1'b0);
    wait_ph(PH_OTB);
  endtask : t_mode1

  task automatic t_mode2();
    set_mode(SEL_EXEC_WAIT, SEL_NONE);
    wait_ph(PH_OTA);
    u_src.drive(1'b1, 1'b0);
    ticks(4);
    check(16'(phase), 16'(PH_DTB));
    check(16'(waveform_out_a), 16'h0000);
    ticks(20);
    check(16'(phase), 16'(PH_OTB));
    check(16'(count), 16'(dur.ot_b));
    u_src.drive(1'b0, 1'b0);
    wait_ph(PH_DTA);
    wait_ph(PH_OTA);
    u_src.drive(1'b1, 1'b0);
    ticks(4);
    u_src.drive(1'b0, 1'b0);
    wait_ph(PH_OTB);
    ticks(8);
    check(16'(phase), 16'(PH_DTA));
  endtask : t_mode2

  task automatic t_mode3();
    set_mode(SEL_EXEC_ACT, SEL_NONE);
    wait_ph(PH_OTA);
    u_src.drive(1'b1, 1'b0);
    ticks(4);
    check(16'(phase), 16'(PH_DTB));
    check(16'(waveform_out_a), 16'h0000);
    ticks(20);
    check(16'(phase), 16'(PH_DTB));
    u_src.drive(1'b0, 1'b0);
    wait_ph(PH_OTB);
    ticks(8);
    check(16'(phase), 16'(PH_DTA));
  endtask : t_mode3

  task automatic t_mode4();
    set_mode(SEL_NONE, SEL_ALL_KEEP);
    wait_ph(PH_OTA);
    u_src.drive(1'b0, 1'b1);
    ticks(4);
    check(16'(waveform_out_a), 16'h0000);
    wait_ph(PH_OTB);
    ticks(1);
    check(16'(waveform_out_b), 16'h0000);
    u_src.drive(1'b0, 1'b0);
    ticks(4);
    check(16'(waveform_out_b), 16'h0001);
  endtask : t_mode4

  task automatic t_mode5();
    set_mode(SEL_ALL_DEAD, SEL_NONE);
    wait_ph(PH_OTA);
    u_src.drive(1'b1, 1'b0);
    ticks(4);
    check(16'(phase), 16'(PH_DTB));
    check(16'(waveform_out_a), 16'h0000);
    ticks(10);
    check(16'(phase), 16'(PH_DTA));
    u_src.drive(1'b0, 1'b0);
    wait_ph(PH_OTA);
    ticks(1);
    check(16'(waveform_out_a), 16'h0001);
  endtask : t_mode5

  task automatic t_mode6();
    set_mode(SEL_ALL_WAIT, SEL_NONE);
    wait_ph(PH_OTA);
    u_src.drive(1'b1, 1'b0);
    ticks(4);
    check(16'(phase), 16'(PH_DTB));
    check(16'(waveform_out_a), 16'h0000);
    ticks(6);
    check(16'(count), 16'h0000);
    u_src.drive(1'b0, 1'b0);
    ticks(4);
    check(16'(phase), 16'(PH_DTB));
    check(16'(count), 16'h0002);
    wait_ph(PH_OTB);
  endtask : t_mode6

  task automatic pulse_restart();
    restart = 1'b1;
    ticks(1);
    restart = 1'b0;
    ticks(2);
  endtask : pulse_restart

  task automatic t_mode7();
    logic [CNT_W-1:0] held;
    set_mode(SEL_ALL_SW, SEL_ALL_SW);
    wait_ph(PH_OTA);
    u_src.drive(1'b0, 1'b1);
    ticks(4);
    held = count;
    check(16'(stopped), 16'h0001);
    check(16'(waveform_out_a), 16'h0000);
    ticks(5);
    check(16'(count), 16'(held));
    pulse_restart();
    check(16'(stopped), 16'h0001);
    u_src.drive(1'b0, 1'b0);
    ticks(4);
    pulse_restart();
    check(16'(stopped), 16'h0000);
    check(16'(phase), 16'(PH_DTA));
  endtask : t_mode7

  task automatic t_mode8();
    set_mode(SEL_NONE, SEL_EDGE_JUMP);
    wait_ph(PH_OTB);
    u_src.drive(1'b0, 1'b1);
    ticks(4);
    check(16'(phase), 16'(PH_DTA));
    check(16'(waveform_out_b), 16'h0000);
    u_src.drive(1'b0, 1'b0);
  endtask : t_mode8

  task automatic t_mode9();
    set_mode(SEL_EDGE_KEEP, SEL_NONE);
    wait_ph(PH_OTA);
    u_src.drive(1'b1, 1'b0);
    ticks(4);
    check(16'(waveform_out_a), 16'h0000);
    check(16'(phase), 16'(PH_OTA));
    wait_ph(PH_OTA);
    ticks(1);
    check(16'(waveform_out_a), 16'h0001);
    u_src.drive(1'b0, 1'b0);
  endtask : t_mode9

  task automatic t_mode10();
    set_mode(SEL_LEVEL_KEEP, SEL_NONE);
    wait_ph(PH_OTA);
    u_src.drive(1'b1, 1'b0);
    ticks(3);
    check(16'(waveform_out_a), 16'h0000);
    u_src.drive(1'b0, 1'b0);
    ticks(4);
    check(16'(waveform_out_a), 16'h0000);
    check(16'(phase), 16'(PH_OTA));
    wait_ph(PH_OTA);
    ticks(1);
    check(16'(waveform_out_a), 16'h0001);
  endtask : t_mode10

  initial begin
    arst_n = 1'b0;
    cnt_en = 1'b0;
    restart = 1'b0;
    sel = '0;
    // Dead times last 8 ticks, on-time A 16 and on-time B 8.
    dur = {12'h007, 12'h007, 12'h00F, 12'h007};
    ticks(4);
    arst_n = 1'b1;
    ticks(3);
    check(16'(phase), 16'(PH_DTA));
    check(16'(waveform_out_a), 16'h0000);
    cnt_en = 1'b1;
    t_none();
    t_mode1();
    t_mode2();
    t_mode3();
    t_mode4();
    t_mode5();
    t_mode6();
    t_mode7();
    t_mode8();
    t_mode9();
    t_mode10();
    stop_test();
  end
endmodule : pfi_fault_modes_test
